//--- core/ppmrb_pkg.sv
package ppmrb_pkg;
  localparam int PORTS = 2;
  localparam int DATA_W = 16;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 5;
  // register indices
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STATUS = 5'h01;
  localparam logic [4:0] IDX_ID_HIGH = 5'h02;
  localparam logic [4:0] IDX_ID_LOW = 5'h03;
  localparam logic [4:0] IDX_ADVERTISE = 5'h04;
  localparam logic [4:0] IDX_PARTNER = 5'h05;
  localparam logic [4:0] IDX_EXPANSION = 5'h06;
  localparam logic [4:0] IDX_MODE_CTRL = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] IDX_INDICATION = 5'h1B;
  localparam logic [4:0] IDX_EVENT_FLAGS = 5'h1D;
  localparam logic [4:0] IDX_EVENT_MASK = 5'h1E;
  localparam logic [4:0] IDX_EXTRA_CTRL = 5'h1F;
  // control bit positions
  localparam int CTRL_SOFT_RESET = 15;
  localparam int CTRL_LOOPBACK = 14;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_AUTONEG = 12;
  localparam int CTRL_POWER_DOWN = 11;
  localparam int CTRL_AN_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  localparam int CTRL_COL_TEST = 7;
  localparam logic [15:0] CTRL_STORE_MASK = 16'h7980;
  // status layout
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_LINK = 2;
  localparam logic [15:0] STATUS_FIXED = 16'h7808;
  // reset values
  localparam logic [15:0] ADVERTISE_RESET = 16'h0001;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  // serial management frame
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HEADER_LAST = 6'h0C;
  localparam logic [5:0] DATA_LAST = 6'h0F;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  typedef enum logic [2:0] {MD_IDLE, MD_HEADER, MD_TA, MD_RDATA, MD_WDATA} ppmrb_md_state_t;
endpackage : ppmrb_pkg

//--- core/ppmrb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module ppmrb_bank #(
  parameter logic [4:0] PORT1_ADDR = 5'h01,
  parameter logic [4:0] PORT2_ADDR = 5'h02,
  parameter logic [15:0] ID_HIGH = 16'h1234,  // arbitrary value
  parameter logic [15:0] ID_LOW = 16'h5670    // arbitrary value
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_mode,
  input wire logic [ppmrb_pkg::PORTS-1:0] autoneg_strap,
  input wire logic [ppmrb_pkg::PORTS-1:0] speed_strap,
  input wire logic [ppmrb_pkg::PORTS-1:0] duplex_strap,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_port,
  input wire logic [ppmrb_pkg::IDX_W-1:0] req_index,
  input wire logic [ppmrb_pkg::DATA_W-1:0] req_wdata,
  output logic resp_valid,
  output logic [ppmrb_pkg::DATA_W-1:0] resp_rdata,
  input wire logic loader_valid,
  input wire logic loader_port,
  input wire logic [ppmrb_pkg::DATA_W-1:0] loader_data,
  input wire logic [ppmrb_pkg::PORTS-1:0] link_up,
  input wire logic [ppmrb_pkg::PORTS-1:0] autoneg_done,
  input wire logic [ppmrb_pkg::PORTS-1:0] negotiated_100,
  input wire logic [ppmrb_pkg::PORTS-1:0] negotiated_full,
  input wire logic [ppmrb_pkg::PORTS-1:0][ppmrb_pkg::DATA_W-1:0] partner_ability,
  input wire logic [ppmrb_pkg::PORTS-1:0][ppmrb_pkg::DATA_W-1:0] event_in,
  output logic [ppmrb_pkg::PORTS-1:0] fabric_loopback_enable,
  output logic [ppmrb_pkg::PORTS-1:0] port_speed_100,
  output logic [ppmrb_pkg::PORTS-1:0] port_full_duplex,
  output logic [ppmrb_pkg::PORTS-1:0] autoneg_enable,
  output logic [ppmrb_pkg::PORTS-1:0] general_power_down,
  output logic [ppmrb_pkg::PORTS-1:0] collision_test_enable,
  output logic [ppmrb_pkg::PORTS-1:0] autoneg_restart,
  output logic [ppmrb_pkg::PORTS-1:0] event_pending
);
  import ppmrb_pkg::*;
  function automatic logic [15:0] ctrl_default(input logic an, input logic sp, input logic dx);
    logic [15:0] v;
    v = ZERO_RESET;
    v[CTRL_SPEED] = an | sp;
    v[CTRL_AUTONEG] = an;
    v[CTRL_DUPLEX] = ~an & dx;
    return v;
  endfunction : ctrl_default
  logic [PORTS-1:0] an_s, sp_s, dx_s, next_restart;
  always_ff @(posedge clk) begin
    if (reset) begin
      an_s <= autoneg_strap;
      sp_s <= speed_strap;
      dx_s <= duplex_strap;
    end
  end
  logic [PORTS-1:0][15:0] ctrl, adv, expn, mode_ctl, spec_modes, indic, flags, emask, extra;
  logic [PORTS-1:0][15:0] next_ctrl, next_adv, next_expn, next_mode_ctl, next_spec_modes;
  logic [PORTS-1:0][15:0] next_indic, next_flags, next_emask, next_extra;
  ppmrb_md_state_t md_state, next_md_state;
  logic [5:0] md_cnt, next_md_cnt;
  logic [15:0] md_shift, next_md_shift, acc_wdata, rd_data;
  logic [4:0] md_idx, next_md_idx, acc_idx;
  logic md_port, next_md_port, md_hit, next_md_hit, md_read, next_md_read, md_wr, next_md_wr;
  logic mdc_q, next_mdio_out, next_mdio_oe, mdc_rise, serial_re;
  logic [12:0] hdr;
  logic acc_re, acc_we, acc_port;
  always_comb begin
    acc_re = serial_mode ? serial_re : (req_valid & ~req_write);
    acc_we = serial_mode ? md_wr : (req_valid & req_write);
    acc_port = serial_mode ? md_port : req_port;
    acc_idx = serial_mode ? md_idx : req_index;
    acc_wdata = serial_mode ? md_shift : req_wdata;
  end
  always_comb begin
    case (acc_idx)
      IDX_CTRL: rd_data = ctrl[acc_port];
      IDX_STATUS: begin
        rd_data = STATUS_FIXED;
        rd_data[STAT_AN_DONE] = autoneg_done[acc_port];
        rd_data[STAT_LINK] = link_up[acc_port];
      end
      IDX_ID_HIGH: rd_data = ID_HIGH;
      IDX_ID_LOW: rd_data = ID_LOW;
      IDX_ADVERTISE: rd_data = adv[acc_port];
      IDX_PARTNER: rd_data = partner_ability[acc_port];
      IDX_EXPANSION: rd_data = expn[acc_port];
      IDX_MODE_CTRL: rd_data = mode_ctl[acc_port];
      IDX_SPECIAL_MODES: rd_data = spec_modes[acc_port];
      IDX_INDICATION: rd_data = indic[acc_port];
      IDX_EVENT_FLAGS: rd_data = flags[acc_port];
      IDX_EVENT_MASK: rd_data = emask[acc_port];
      IDX_EXTRA_CTRL: rd_data = extra[acc_port];
      default: rd_data = ZERO_RESET;
    endcase
  end
  always_comb begin
    logic cw;
    logic [15:0] cd;
    logic hit;
    cw = 1'b0;
    cd = ZERO_RESET;
    hit = 1'b0;
    next_ctrl = ctrl;
    next_adv = adv;
    next_expn = expn;
    next_mode_ctl = mode_ctl;
    next_spec_modes = spec_modes;
    next_indic = indic;
    next_emask = emask;
    next_extra = extra;
    next_flags = flags;
    next_restart = '0;
    for (int p = 0; p < PORTS; p++) begin
      hit = (acc_port == p[0]);
      if (acc_re && hit && acc_idx == IDX_EVENT_FLAGS) begin
        next_flags[p] = ZERO_RESET;
      end
      if (acc_we && hit) begin
        case (acc_idx)
          IDX_ADVERTISE: next_adv[p] = acc_wdata;
          IDX_EXPANSION: next_expn[p] = acc_wdata;
          IDX_MODE_CTRL: next_mode_ctl[p] = acc_wdata;
          IDX_SPECIAL_MODES: next_spec_modes[p] = acc_wdata;
          IDX_INDICATION: next_indic[p] = acc_wdata;
          IDX_EVENT_MASK: next_emask[p] = acc_wdata;
          IDX_EXTRA_CTRL: next_extra[p] = acc_wdata;
          default: next_adv[p] = next_adv[p];
        endcase
      end
      cw = (loader_valid && loader_port == p[0]) || (acc_we && hit && acc_idx == IDX_CTRL);
      cd = (loader_valid && loader_port == p[0]) ? loader_data : acc_wdata;
      if (cw) begin
        if (cd[CTRL_SOFT_RESET]) begin
          next_ctrl[p] = ctrl_default(an_s[p], sp_s[p], dx_s[p]);
          next_adv[p] = ADVERTISE_RESET;
          next_expn[p] = ZERO_RESET;
          next_mode_ctl[p] = ZERO_RESET;
          next_indic[p] = ZERO_RESET;
          next_emask[p] = ZERO_RESET;
          next_extra[p] = ZERO_RESET;
          next_flags[p] = ZERO_RESET;
        end else begin
          next_ctrl[p] = cd & CTRL_STORE_MASK;
          next_restart[p] = cd[CTRL_AN_RESTART];
        end
      end
      next_flags[p] = next_flags[p] | event_in[p];
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int p = 0; p < PORTS; p++) begin
        ctrl[p] <= ctrl_default(autoneg_strap[p], speed_strap[p], duplex_strap[p]);
      end
      adv <= {PORTS{ADVERTISE_RESET}};
      expn <= '0;
      mode_ctl <= '0;
      spec_modes <= '0;
      indic <= '0;
      flags <= '0;
      emask <= '0;
      extra <= '0;
      autoneg_restart <= '0;
    end else begin
      ctrl <= next_ctrl;
      adv <= next_adv;
      expn <= next_expn;
      mode_ctl <= next_mode_ctl;
      spec_modes <= next_spec_modes;
      indic <= next_indic;
      flags <= next_flags;
      emask <= next_emask;
      extra <= next_extra;
      autoneg_restart <= next_restart;
    end
  end
  always_comb begin
    mdc_rise = mdc & ~mdc_q;
    serial_re = mdc_rise && md_state == MD_TA && md_cnt == 6'h00 && md_read && md_hit;
    hdr = {md_shift[11:0], mdio_in};
    next_md_state = md_state;
    next_md_cnt = md_cnt;
    next_md_shift = md_shift;
    next_md_port = md_port;
    next_md_idx = md_idx;
    next_md_hit = md_hit;
    next_md_read = md_read;
    next_md_wr = 1'b0;
    next_mdio_out = mdio_out;
    next_mdio_oe = mdio_oe;
    if (mdc_rise) begin
      case (md_state)
        MD_IDLE: begin
          if (mdio_in) begin
            next_md_cnt = (md_cnt < PREAMBLE_LEN) ? md_cnt + 6'h01 : md_cnt;
          end else if (md_cnt >= PREAMBLE_LEN) begin
            next_md_state = MD_HEADER;
            next_md_cnt = 6'h00;
          end else begin
            next_md_cnt = 6'h00;
          end
        end
        MD_HEADER: begin
          next_md_shift = {md_shift[14:0], mdio_in};
          next_md_cnt = md_cnt + 6'h01;
          if (md_cnt == HEADER_LAST) begin
            next_md_cnt = 6'h00;
            next_md_port = (hdr[9:5] == PORT2_ADDR);
            next_md_hit = serial_mode && (hdr[9:5] == PORT1_ADDR || hdr[9:5] == PORT2_ADDR);
            next_md_read = (hdr[11:10] == OP_READ);
            next_md_idx = hdr[4:0];
            next_md_state = (hdr[12] && (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) ? MD_TA : MD_IDLE;
          end
        end
        MD_TA: begin
          if (md_cnt == 6'h00) begin
            next_md_cnt = 6'h01;
            if (md_read && md_hit) begin
              next_md_shift = rd_data;
              next_mdio_oe = 1'b1;
              next_mdio_out = 1'b0;
            end
          end else begin
            next_md_cnt = 6'h00;
            next_md_state = md_read ? MD_RDATA : MD_WDATA;
            if (md_read && md_hit) begin
              next_mdio_out = md_shift[15];
              next_md_shift = {md_shift[14:0], 1'b0};
            end
          end
        end
        MD_RDATA: begin
          if (md_cnt == DATA_LAST) begin
            next_mdio_oe = 1'b0;
            next_mdio_out = 1'b0;
            next_md_cnt = 6'h00;
            next_md_state = MD_IDLE;
          end else begin
            next_md_cnt = md_cnt + 6'h01;
            if (md_hit) begin
              next_mdio_out = md_shift[15];
              next_md_shift = {md_shift[14:0], 1'b0};
            end
          end
        end
        MD_WDATA: begin
          next_md_shift = {md_shift[14:0], mdio_in};
          next_md_cnt = md_cnt + 6'h01;
          if (md_cnt == DATA_LAST) begin
            next_md_wr = md_hit;
            next_md_cnt = 6'h00;
            next_md_state = MD_IDLE;
          end
        end
        default: next_md_state = MD_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      md_state <= MD_IDLE;
      md_cnt <= 6'h00;
      md_shift <= 16'h0000;
      md_port <= 1'b0;
      md_idx <= 5'h00;
      md_hit <= 1'b0;
      md_read <= 1'b0;
      md_wr <= 1'b0;
      mdc_q <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      md_state <= next_md_state;
      md_cnt <= next_md_cnt;
      md_shift <= next_md_shift;
      md_port <= next_md_port;
      md_idx <= next_md_idx;
      md_hit <= next_md_hit;
      md_read <= next_md_read;
      md_wr <= next_md_wr;
      mdc_q <= mdc;
      mdio_out <= next_mdio_out;
      mdio_oe <= next_mdio_oe;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      resp_valid <= 1'b0;
      resp_rdata <= 16'h0000;
      fabric_loopback_enable <= '0;
      port_speed_100 <= '0;
      port_full_duplex <= '0;
      autoneg_enable <= '0;
      general_power_down <= '0;
      collision_test_enable <= '0;
      event_pending <= '0;
    end else begin
      resp_valid <= req_valid;
      resp_rdata <= (req_valid && !req_write && !serial_mode) ? rd_data : 16'h0000;
      for (int p = 0; p < PORTS; p++) begin
        fabric_loopback_enable[p] <= ctrl[p][CTRL_LOOPBACK];
        autoneg_enable[p] <= ctrl[p][CTRL_AUTONEG];
        port_speed_100[p] <= ctrl[p][CTRL_AUTONEG] ? negotiated_100[p] : ctrl[p][CTRL_SPEED];
        port_full_duplex[p] <= ctrl[p][CTRL_AUTONEG] ? negotiated_full[p] : ctrl[p][CTRL_DUPLEX];
        general_power_down[p] <= ctrl[p][CTRL_POWER_DOWN];
        collision_test_enable[p] <= ctrl[p][CTRL_COL_TEST];
        event_pending[p] <= |(flags[p] & emask[p]);
      end
    end
  end
endmodule : ppmrb_bank
`default_nettype wire

//--- test/ppmrb_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ppmrb_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_mode,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_port,
  input wire logic [ppmrb_pkg::IDX_W-1:0] req_index,
  input wire logic [ppmrb_pkg::DATA_W-1:0] req_wdata,
  input wire logic loader_valid,
  input wire logic loader_port,
  input wire logic [ppmrb_pkg::DATA_W-1:0] loader_data,
  input wire logic resp_valid,
  input wire logic [ppmrb_pkg::DATA_W-1:0] resp_rdata,
  input wire logic mdio_oe,
  input wire logic [ppmrb_pkg::PORTS-1:0] fabric_loopback_enable,
  input wire logic [ppmrb_pkg::PORTS-1:0] autoneg_restart,
  input wire logic [ppmrb_pkg::PORTS-1:0] event_pending
);
  import ppmrb_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_resp_pulse: assert property (req_valid |=> resp_valid)
    else $error("request got no answer");
  a_resp_cause: assert property (resp_valid |-> $past(req_valid))
    else $error("answer without request");
  a_refused_zero: assert property (req_valid && serial_mode |=> resp_rdata == 16'h0000)
    else $error("refused access returned data");
  a_write_rdata: assert property (req_valid && req_write |=> resp_rdata == 16'h0000)
    else $error("write answer carried data");
  a_unimpl_zero: assert property (req_valid && req_index inside {[5'h07:5'h10], [5'h13:5'h1A], 5'h1C}
    |=> resp_rdata == 16'h0000) else $error("unimplemented index read nonzero");
  a_ctrl_reserved: assert property (req_valid && !req_write && req_index == IDX_CTRL
    |=> (resp_rdata & 16'h867F) == 16'h0000) else $error("reserved control bits read nonzero");
  a_serial_quiet: assert property (!serial_mode |-> !mdio_oe)
    else $error("mdio driven outside serial mode");
  a_loop_follow: assert property ((req_valid && req_write && req_port && req_index == IDX_CTRL && !req_wdata[15]
    && !serial_mode && !loader_valid) ##1 (!req_valid && !loader_valid)
    |=> fabric_loopback_enable[1] == $past(req_wdata[CTRL_LOOPBACK], 2)) else $error("loopback output wrong");
  logic restart_cause;
  always_ff @(posedge clk) begin
    restart_cause <= serial_mode || (req_valid && req_write && req_port && req_index == IDX_CTRL && req_wdata[9])
      || (loader_valid && loader_port && loader_data[9]);
  end
  a_restart_cause: assert property (autoneg_restart[1] |-> restart_cause)
    else $error("restart pulse without cause");
  a_restart_pulse: assert property (req_valid && req_write && req_port && req_index == IDX_CTRL
    && req_wdata[9] && !req_wdata[15] && !serial_mode && !loader_valid |=> autoneg_restart[1])
    else $error("restart write gave no pulse");
  c_serial_read: cover property (mdio_oe);
  c_loader: cover property (loader_valid);
  c_pending: cover property (event_pending[0]);
endmodule : ppmrb_checker
bind ppmrb_bank ppmrb_checker chk (.clk, .reset, .serial_mode, .req_valid, .req_write, .req_port, .req_index,
  .req_wdata, .loader_valid, .loader_port, .loader_data, .resp_valid, .resp_rdata, .mdio_oe,
  .fabric_loopback_enable, .autoneg_restart, .event_pending);
`default_nettype wire

//--- test/ppmrb_mgmt_host.sv
`timescale 1ns/1ps
`default_nettype none
module ppmrb_mgmt_host (
  input wire logic clk,
  output logic mdc,
  input wire logic mdio_in,
  output logic drive,
  output logic drive_en
);
  initial begin
    mdc = 1'h0;
    drive = 1'h1;
    drive_en = 1'h0;
  end
  // one frame; clock idles low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] s;
    s = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      drive_en <= !(op == 2'h2 && i < 18);
      drive <= s[i];
      repeat (4) @(posedge clk);
      if (i < 16) rd[i] = mdio_in;
      mdc <= 1'h1;
      repeat (4) @(posedge clk);
      mdc <= 1'h0;
    end
    drive_en <= 1'h0;
    @(posedge clk);
  endtask : frame
endmodule : ppmrb_mgmt_host
`default_nettype wire

//--- test/ppmrb_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module ppmrb_bank_tb;
  import ppmrb_pkg::*;
  typedef struct {logic p; logic w; logic [4:0] ix; logic [15:0] wd; logic [15:0] ex;} ppmrb_row_t;
  localparam logic [15:0] ID_H = 16'hA5C3; // arbitrary value
  localparam logic [15:0] ID_L = 16'h3C5A; // arbitrary value
  localparam logic [15:0] PA = 16'h45E1;
  logic clk = 0, reset = 1, serial_mode = 0, req_valid = 0, req_write = 0, req_port = 0;
  logic loader_valid = 0, loader_port = 0, mdc, mdio_in, mdio_out, mdio_oe, h_drive, h_en, resp_valid;
  logic [4:0] req_index = 0;
  logic [15:0] req_wdata = 0, loader_data = 0, rd, resp_rdata;
  logic [1:0] autoneg_strap = 2'h1, speed_strap = 2'h2, duplex_strap = 2'h2, link_up = 2'h1, autoneg_done = 2'h2;
  logic [1:0] negotiated_100 = 0, negotiated_full = 0, fabric_loopback_enable, port_speed_100, port_full_duplex;
  logic [1:0] autoneg_enable, general_power_down, collision_test_enable, autoneg_restart, event_pending;
  logic [1:0][15:0] partner_ability = {PA, 16'h0000}, event_in = 0;
  int mismatches = 0, n_compared = 0, cycles = 0, n_restart = 0;
  ppmrb_row_t rows [20];
  assign mdio_in = mdio_oe ? mdio_out : (h_en ? h_drive : 1'h1);
  ppmrb_bank #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) dut (.clk, .reset, .serial_mode, .autoneg_strap, .speed_strap,
    .duplex_strap, .mdc, .mdio_in, .mdio_out, .mdio_oe, .req_valid, .req_write, .req_port, .req_index,
    .req_wdata, .resp_valid, .resp_rdata, .loader_valid, .loader_port, .loader_data, .link_up, .autoneg_done,
    .negotiated_100, .negotiated_full, .partner_ability, .event_in, .fabric_loopback_enable, .port_speed_100,
    .port_full_duplex, .autoneg_enable, .general_power_down, .collision_test_enable, .autoneg_restart,
    .event_pending);
  ppmrb_mgmt_host host (.clk, .mdc, .mdio_in, .drive(h_drive), .drive_en(h_en));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (autoneg_restart[1]) n_restart++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic acc(input logic p, input logic w, input logic [4:0] ix, input logic [15:0] wd);
    req_valid <= 1'h1;
    req_write <= w;
    req_port <= p;
    req_index <= ix;
    req_wdata <= wd;
    @(posedge clk);
    req_valid <= 1'h0;
    #1;
    `CHK("resp_valid", 1'h1, resp_valid)
    rd = resp_rdata;
    @(posedge clk);
  endtask : acc
  task automatic rchk(input string nm, input logic p, input logic [4:0] ix, input logic [15:0] ex);
    acc(p, 1'h0, ix, 16'h0000);
    `CHK(nm, ex, rd)
  endtask : rchk
  initial begin
    rows = '{'{0, 0, 5'h00, 0, 16'h3000}, '{1, 0, 5'h00, 0, 16'h2100}, '{0, 0, 5'h01, 0, 16'h780C},
      '{1, 0, 5'h01, 0, 16'h7828}, '{0, 0, 5'h02, 0, ID_H}, '{1, 0, 5'h03, 0, ID_L}, '{0, 0, 5'h04, 0, 16'h0001},
      '{1, 0, 5'h05, 0, PA}, '{0, 0, 5'h06, 0, 16'h0000}, '{0, 1, 5'h07, 16'hFFFF, 0}, '{0, 0, 5'h07, 0, 0},
      '{1, 1, 5'h00, 16'h67FF, 0}, '{1, 0, 5'h00, 0, 16'h6180}, '{0, 0, 5'h00, 0, 16'h3000},
      '{0, 1, 5'h11, 16'h0A11, 0}, '{0, 1, 5'h1B, 16'h0A1B, 0}, '{0, 1, 5'h1F, 16'h0A1F, 0},
      '{0, 0, 5'h11, 0, 16'h0A11}, '{0, 0, 5'h1B, 0, 16'h0A1B}, '{0, 0, 5'h1F, 0, 16'h0A1F}};
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    foreach (rows[i]) begin
      acc(rows[i].p, rows[i].w, rows[i].ix, rows[i].wd);
      `CHK("row", rows[i].ex, rd)
    end
    `CHK("cfg", 5'h1E, {fabric_loopback_enable[1], port_speed_100[1], port_full_duplex[1],
      collision_test_enable[1], autoneg_enable[1]})
    `CHK("restart", 1, n_restart)
    $display("table done");
    acc(1, 1, IDX_CTRL, 16'h0800);
    negotiated_full <= 2'h1;
    autoneg_done <= 2'h3;
    repeat (2) @(posedge clk);
    `CHK("pd", 4'h8, {general_power_down[1], port_speed_100[1], port_full_duplex[1], autoneg_enable[1]})
    `CHK("an", 3'h5, {autoneg_enable[0], port_speed_100[0], port_full_duplex[0]})
    rchk("status", 0, IDX_STATUS, 16'h782C);
    acc(1, 1, IDX_ADVERTISE, 16'h01E1);
    acc(1, 1, IDX_SPECIAL_MODES, 16'h00A5);
    acc(1, 1, IDX_CTRL, 16'h8000);
    rchk("soft", 1, IDX_CTRL, 16'h2100);
    rchk("soft adv", 1, IDX_ADVERTISE, 16'h0001);
    rchk("immune", 1, IDX_SPECIAL_MODES, 16'h00A5);
    loader_data <= 16'h4100;
    loader_valid <= 1'h1;
    @(posedge clk);
    loader_valid <= 1'h0;
    @(posedge clk);
    rchk("loader", 0, IDX_CTRL, 16'h4100);
    acc(0, 1, IDX_EVENT_MASK, 16'hFFFF);
    event_in[0] <= 16'h0004;
    @(posedge clk);
    event_in[0] <= 16'h0000;
    repeat (2) @(posedge clk);
    `CHK("pend", 1'h1, event_pending[0])
    rchk("flags", 0, IDX_EVENT_FLAGS, 16'h0004);
    rchk("clear", 0, IDX_EVENT_FLAGS, 16'h0000);
    `CHK("idle", 1'h0, event_pending[0])
    $display("hand tests done");
    serial_mode <= 1'h1;
    acc(0, 1, IDX_CTRL, 16'h0000);
    rchk("refused", 0, IDX_CTRL, 16'h0000);
    host.frame(2'h2, 5'h01, IDX_CTRL, 16'h0000, rd);
    `CHK("kept", 16'h4100, rd)
    host.frame(2'h1, 5'h01, IDX_CTRL, 16'h2000, rd);
    host.frame(2'h2, 5'h01, IDX_CTRL, 16'h0000, rd);
    `CHK("mdio p1", 16'h2000, rd)
    host.frame(2'h2, 5'h02, IDX_CTRL, 16'h0000, rd);
    `CHK("mdio p2", 16'h2100, rd)
    host.frame(2'h2, 5'h03, IDX_CTRL, 16'h0000, rd);
    `CHK("no answer", 16'hFFFF, rd)
    serial_mode <= 1'h0;
    @(posedge clk);
    rchk("p1 ctrl", 0, IDX_CTRL, 16'h2000);
    $display("serial done");
    autoneg_strap <= 2'h0;
    speed_strap <= 2'h3;
    reset <= 1'h1;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rchk("strap", 0, IDX_CTRL, 16'h2000);
    rchk("adv", 0, IDX_ADVERTISE, 16'h0001);
    $display("reset done");
    results();
  end
endmodule : ppmrb_bank_tb
`default_nettype wire
